// >>> multi_group_pwm_generator.sv
// Sixteen-output PWM generator in four groups, with an AXI4-Lite register slave.
// Assumes one clock, synchronous active-low reset, and a well-behaved AXI master.
// How it works
// - Software picks edge-aligned or center-aligned waveforms.
// - Each group is paired (complementary pair outputs) or non-paired (four independent outputs).
// - There are four independent groups of four outputs, sixteen in all.
// - Each group's four outputs form two pairs, both following the group's pairing setting.
// - Center-aligned operation offers single-update and double-update, chosen by software.
// - Single-update loads new duties once per period, so pulses are symmetric about the midpoint.
// - Double-update loads duties at period start and again at midpoint, allowing asymmetry.
// - Software routes the outputs to the external-port address pins or to the pin matrix.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`include "pwm_gen_cfg.svh"
module multi_group_pwm_generator #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Waveform outputs
    output logic [15:0] ext_port_pwm_q,
    output logic [15:0] peripheral_pin_matrix_q
);
    import pwm_gen_pkg::*;

    function automatic logic is_duty(input logic [ADDR_W-1:0] a);
        return (a >= `DUTY_BASE_OFS) && (a <= `DUTY_LAST_OFS) && (a[1:0] == 2'b00);
    endfunction : is_duty

    function automatic logic [3:0] duty_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - `DUTY_BASE_OFS;
        return d[5:2];
    endfunction : duty_idx

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == `CTRL_OFS) || (a == `PERIOD_OFS) || (a == `STATUS_OFS) || is_duty(a);
    endfunction : is_mapped

    // Control and shadow registers.
    logic en_q, center_q, double_q, route_q;
    logic [3:0] pair_q;
    count_t period_q, per_act_q, cnt_q, cnt_d;
    count_t duty_q [16];
    count_dir_t dir_q, dir_d;

    // AXI state.
    logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_do = aw_got_q && w_got_q;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] ctrl_word = {24'h0, pair_q, route_q, double_q, center_q, en_q};
    wire [31:0] ctrl_new = merge_bytes(ctrl_word, wdata_q, wstrb_q);
    wire [31:0] per_new = merge_bytes({16'h0, period_q}, wdata_q, wstrb_q);
    wire [31:0] duty_new = merge_bytes({16'h0, duty_q[duty_idx(awaddr_q)]}, wdata_q, wstrb_q);

    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready = !w_got_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Timebase decode: while enabled, period end and, in double-update, the midpoint are the only update points.
    wire [16:0] cnt_inc = {1'b0, cnt_q} + 17'h00001;
    wire reach_top = cnt_inc >= {1'b0, per_act_q};
    wire period_end = center_q ? (dir_q == dir_down && cnt_q <= 16'h0001) : reach_top;
    wire mid_point = center_q && (dir_q == dir_up) && reach_top;
    wire load = !en_q || period_end || (center_q && double_q && mid_point);

    // Center mode compares against the distance from the midpoint, so pulses centre on it.
    wire [31:0] read_mux =
        (s_axi_araddr == `CTRL_OFS) ? ctrl_word :
        (s_axi_araddr == `PERIOD_OFS) ? {16'h0, period_q} :
        (s_axi_araddr == `STATUS_OFS) ? {cnt_q, 15'h0, (dir_q == dir_down)} :
        is_duty(s_axi_araddr) ? {16'h0, duty_q[duty_idx(s_axi_araddr)]} : 32'h0;

    pwm_timebase_if tb ();
    assign tb.cmp_count = center_q ? (per_act_q - cnt_q) : cnt_q;
    assign tb.run = en_q;
    assign tb.load = load;

    always_comb begin
        cnt_d = 16'h0;
        dir_d = dir_up;
        if (en_q && center_q) begin
            if (dir_q == dir_up) begin
                cnt_d = mid_point ? per_act_q : cnt_inc[15:0];
                dir_d = mid_point ? dir_down : dir_up;
            end else begin
                cnt_d = period_end ? 16'h0 : cnt_q - 16'h0001;
                dir_d = period_end ? dir_up : dir_down;
            end
        end else if (en_q) begin
            cnt_d = period_end ? 16'h0 : cnt_inc[15:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 16'h0;
            dir_q <= dir_up;
            per_act_q <= `PERIOD_RESET;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            if (!en_q || period_end) begin
                per_act_q <= period_q;
            end
        end
    end

    // Register writes; aw and w may arrive in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            en_q <= 1'b0;
            center_q <= 1'b0;
            double_q <= 1'b0;
            route_q <= 1'b0;
            pair_q <= 4'h0;
            period_q <= `PERIOD_RESET;
            for (int k = 0; k < 16; k++) begin
                duty_q[k] <= `DUTY_RESET;
            end
        end else begin
            if (aw_take) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= is_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
                if (awaddr_q == `CTRL_OFS) begin
                    en_q <= ctrl_new[`CTRL_EN_BIT];
                    center_q <= ctrl_new[`CTRL_CENTER_BIT];
                    double_q <= ctrl_new[`CTRL_DOUBLE_BIT];
                    route_q <= ctrl_new[`CTRL_ROUTE_BIT];
                    pair_q <= ctrl_new[`CTRL_PAIR_MSB:`CTRL_PAIR_LSB];
                end
                if (awaddr_q == `PERIOD_OFS) begin
                    period_q <= per_new[15:0];
                end
                if (is_duty(awaddr_q)) begin
                    duty_q[duty_idx(awaddr_q)] <= duty_new[15:0];
                end
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= read_mux;
            rresp_q <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Four identical groups share one timebase.
    logic [15:0] waves;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_grp
            logic [63:0] dflat;
            assign dflat = {duty_q[4*g+3], duty_q[4*g+2], duty_q[4*g+1], duty_q[4*g]};
            pwm_group u_grp (
                .aclk(aclk),
                .aresetn(aresetn),
                .tb(tb.group),
                .paired(pair_q[g]),
                .duty_shadow(dflat),
                .wave_q(waves[4*g +: 4])
            );
        end
    endgenerate

    // The unselected destination is held low rather than left floating.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_port_pwm_q <= 16'h0;
            peripheral_pin_matrix_q <= 16'h0;
        end else begin
            ext_port_pwm_q <= route_q ? 16'h0 : waves;
            peripheral_pin_matrix_q <= route_q ? waves : 16'h0;
        end
    end

    a_edge_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        en_q && !center_q && reach_top ##1 en_q && !center_q |-> cnt_q == 16'h0)
        else $error("edge-aligned counter did not wrap at period end");
    a_center_turn: assert property (@(posedge aclk) disable iff (!aresetn)
        en_q && mid_point |=> (dir_q == dir_down) && (cnt_q == $past(per_act_q)))
        else $error("center-aligned counter did not turn at the midpoint");
    a_no_extra_load: assert property (@(posedge aclk) disable iff (!aresetn)
        en_q && !period_end && !(double_q && mid_point) |-> !load)
        else $error("load outside an update point");
    a_single_update: assert property (@(posedge aclk) disable iff (!aresetn)
        en_q && center_q && !double_q && load |-> period_end && dir_q == dir_down)
        else $error("single-update loaded away from period start");
    a_double_update: assert property (@(posedge aclk) disable iff (!aresetn)
        en_q && center_q && double_q && mid_point |-> load)
        else $error("double-update missed the midpoint load");
    a_period_shadow: assert property (@(posedge aclk) disable iff (!aresetn)
        en_q && !period_end |=> per_act_q == $past(per_act_q))
        else $error("active period changed mid-period");
    a_route_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        route_q |=> (ext_port_pwm_q == 16'h0) && (peripheral_pin_matrix_q == $past(waves)))
        else $error("routing to pin matrix is wrong");
    a_group_count: assert property (@(posedge aclk) disable iff (!aresetn)
        !route_q |=> ext_port_pwm_q == $past(waves))
        else $error("sixteen outputs not carried to the external port");
endmodule : multi_group_pwm_generator

// >>> multi_group_pwm_generator_tb_top.sv
// Self-checking bench of the waveform group set over its register slave.
// Assumes the design, its package, header and load model are compiled first.
`include "pwm_gen_cfg.svh"
`define CHK(g, e) begin \
    cmp_count++; \
    if (32'(g) !== 32'(e)) begin \
        err_total++; \
        $display("wrong value at %0t: got %h expected %h", $time, 32'(g), 32'(e)); \
    end \
end
module multi_group_pwm_generator_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pwm_gen_pkg::*;
    logic aclk = 0, aresetn = 0, clr = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] ext_w, pin_w, ext_hi [16], ext_rise [16], pin_hi [16], pin_rise [16];
    logic [31:0] d;
    int err_total = 0, cmp_count = 0;
    always #2.5 aclk = ~aclk;
    multi_group_pwm_generator i_multi_group_pwm_generator (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ext_port_pwm_q(ext_w), .peripheral_pin_matrix_q(pin_w));
    pwm_load_model i_pwm_load_model_ext (.aclk(aclk), .clr(clr), .wave(ext_w),
        .hi_q(ext_hi), .rise_q(ext_rise));
    pwm_load_model i_pwm_load_model_pin (.aclk(aclk), .clr(clr), .wave(pin_w),
        .hi_q(pin_hi), .rise_q(pin_rise));

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        bit aw = 0, w = 0, fin = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!fin) begin
            @(posedge aclk);
            fin = aw && w && s_axi_bvalid === 1'b1;
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        bit ar = 0, fin = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!fin) begin
            @(posedge aclk);
            fin = ar && s_axi_rvalid === 1'b1;
            if (!ar && s_axi_arready === 1'b1) begin
                ar = 1;
                s_axi_arvalid <= 1'b0;
            end
        end
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] rs;
        axi_wr(a, v, rs);
        `CHK(rs, `RESP_OKAY)
    endtask : wr

    // Duties are written while disabled, so the shadows load them at once.
    task automatic setup(input logic [7:0] ctrl, input logic [15:0] per);
        wr(`CTRL_OFS, 32'h0);
        wr(`PERIOD_OFS, 32'(per));
        for (int n = 0; n < 16; n++) wr(8'(`DUTY_BASE_OFS + 4 * n), 32'((n * 3) % 5));
        wr(`CTRL_OFS, 32'(ctrl));
        repeat (40) @(posedge aclk);
    endtask : setup

    task automatic measure(input int w);
        @(posedge aclk);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (w) @(posedge aclk);
        #1;
    endtask : measure

    task automatic t_regs;
        for (int n = 0; n < 19; n++) begin
            axi_rd(n < 3 ? 8'(4 * n) : 8'(`DUTY_BASE_OFS + 4 * (n - 3)), d, r);
            `CHK(d, n == 1 ? 32'(`PERIOD_RESET) : 32'h0)
            `CHK(r, `RESP_OKAY)
        end
        // Only the low byte lane is enabled, so the upper period byte keeps its reset value.
        s_axi_wstrb <= 4'h1;
        axi_wr(`PERIOD_OFS, 32'h0000_1234, r);
        s_axi_wstrb <= 4'hf;
        `CHK(r, `RESP_OKAY)
        axi_rd(`PERIOD_OFS, d, r);
        `CHK(d, 32'((`PERIOD_RESET & 16'hff00) | 16'h0034))
        axi_wr(8'h50, 32'h1, r);
        `CHK(r, `RESP_SLVERR)
        axi_wr(8'h11, 32'h1, r);
        `CHK(r, `RESP_SLVERR)
        axi_rd(8'h50, d, r);
        `CHK(r, `RESP_SLVERR)
        `CHK(d, 32'h0)
    endtask : t_regs

    // Window of 80 cycles spans whole periods of both alignments at period 4.
    task automatic t_wave(input logic [7:0] ctrl);
        int dv, e;
        setup(ctrl, 16'h0004);
        measure(80);
        for (int n = 0; n < 16; n++) begin
            dv = ctrl[4 + n / 4] && n[0] ? ((n - 1) * 3) % 5 : (n * 3) % 5;
            e = ctrl[1] ? (dv == 0 ? 0 : 2 * dv - 1) * 10 : dv * 20;
            if (ctrl[4 + n / 4] && n[0]) e = 80 - e;
            `CHK(ctrl[3] ? pin_hi[n] : ext_hi[n], e)
            `CHK(ctrl[3] ? ext_hi[n] : pin_hi[n], 0)
        end
    endtask : t_wave

    // A duty raised mid-period must not add a second rising edge in that period.
    task automatic t_shadow;
        setup(8'h01, 16'h0008);
        fork
            measure(80);
            begin
                repeat (15) @(posedge aclk);
                wr(8'(`DUTY_BASE_OFS + 4), 32'h6);
            end
        join
        `CHK(ext_rise[1], 10)
        `CHK(ext_rise[3], 10)
        measure(80);
        `CHK(ext_hi[1], 60)
    endtask : t_shadow

    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_wave(8'h01);
        t_wave(8'h59);
        t_wave(8'ha3);
        t_wave(8'h0f);
        t_shadow();
        summarize();
    end

    // Whole run is under two thousand cycles; this bound only catches a hang.
    initial begin
        #200us;
        err_total++;
        summarize();
    end
endmodule : multi_group_pwm_generator_tb_top

// >>> pwm_gen_cfg.svh
// Register map, field positions and reset values of the waveform group set.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef PWM_GEN_CFG_SVH
`define PWM_GEN_CFG_SVH
`define CTRL_OFS 8'h00
`define PERIOD_OFS 8'h04
`define STATUS_OFS 8'h08
`define DUTY_BASE_OFS 8'h10
`define DUTY_LAST_OFS 8'h4c
`define CTRL_EN_BIT 0
`define CTRL_CENTER_BIT 1
`define CTRL_DOUBLE_BIT 2
`define CTRL_ROUTE_BIT 3
`define CTRL_PAIR_LSB 4
`define CTRL_PAIR_MSB 7
`define PERIOD_RESET 16'h00ff
`define DUTY_RESET 16'h0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> pwm_gen_pkg.sv
// Types and shared helpers of the waveform group set.
// Assumes nothing beyond a SystemVerilog compiler.
package pwm_gen_pkg;
    typedef logic [15:0] count_t;
    typedef enum logic {dir_up, dir_down} count_dir_t;

    // Byte-lane merge of an AXI write into a stored word.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                                input logic [31:0] new_w,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction : merge_bytes
endpackage : pwm_gen_pkg

// >>> pwm_group.sv
// One group of four outputs organised as two pairs.
// Assumes the timebase load pulse marks the update points.
`include "pwm_gen_cfg.svh"
module pwm_group (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Timebase and settings
    pwm_timebase_if.group tb,
    input wire logic paired,
    input wire logic [63:0] duty_shadow,
    // Waveforms
    output logic [3:0] wave_q
);
    import pwm_gen_pkg::*;

    count_t act_q [4];
    logic [3:0] raw;
    logic [3:0] wave_d;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_cmp
            assign raw[i] = tb.run && (tb.cmp_count < act_q[i]);
        end
    endgenerate

    // Paired mode uses the even output's duty and drives the odd one as its complement.
    assign wave_d[0] = raw[0];
    assign wave_d[2] = raw[2];
    assign wave_d[1] = paired ? (tb.run && !raw[0]) : raw[1];
    assign wave_d[3] = paired ? (tb.run && !raw[2]) : raw[3];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < 4; k++) begin
                act_q[k] <= `DUTY_RESET;
            end
        end else if (tb.load) begin
            for (int k = 0; k < 4; k++) begin
                act_q[k] <= duty_shadow[16*k +: 16];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_q <= 4'h0;
        end else begin
            wave_q <= wave_d;
        end
    end

    a_shadow_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !tb.load |=> (act_q[0] == $past(act_q[0])) && (act_q[3] == $past(act_q[3])))
        else $error("active duty changed outside an update point");
    a_pair_compl: assert property (@(posedge aclk) disable iff (!aresetn)
        paired && tb.run |=> (wave_q[1] == !wave_q[0]) && (wave_q[3] == !wave_q[2]))
        else $error("paired outputs are not complementary");
    a_indep_out: assert property (@(posedge aclk) disable iff (!aresetn)
        !paired && tb.run && (tb.cmp_count < act_q[1]) |=> wave_q[1])
        else $error("independent output did not follow its own duty");
endmodule : pwm_group

// >>> pwm_load_model.sv
// Load model of the switching stages: counts high cycles and rising edges per output.
// Assumes the bench pulses clr for one clock to open a counting window.
module pwm_load_model (
    // Clock and window control
    input wire logic aclk,
    input wire logic clr,
    // Waveforms from the generator
    input wire logic [15:0] wave,
    // Counts since the last clear
    output logic [15:0] hi_q [16],
    output logic [15:0] rise_q [16]
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] last_q;
    // Edges are counted against the previous sample, so a glitch shows as an extra edge.
    always_ff @(posedge aclk) begin
        last_q <= wave;
        for (int i = 0; i < 16; i++) begin
            hi_q[i] <= clr ? 16'h0000 : hi_q[i] + 16'(wave[i]);
            rise_q[i] <= clr ? 16'h0000 : rise_q[i] + 16'(wave[i] && !last_q[i]);
        end
    end
endmodule : pwm_load_model

// >>> pwm_timebase_if.sv
// Timebase shared from the counter to every output group.
// Assumes all users sit on the same clock.
interface pwm_timebase_if;
    import pwm_gen_pkg::*;
    count_t cmp_count;
    logic run;
    logic load;
    modport drive (output cmp_count, output run, output load);
    modport group (input cmp_count, input run, input load);
endinterface : pwm_timebase_if
